// ---- dv/bdr_switch_model.sv ----
`timescale 1ns/1ps
module bdr_switch_model (
    // Contact
    input  wire logic        held,
    input  wire logic [3:0]  idx,
    input  wire logic        level,
    // Pins
    output logic      [15:0] pins
);
    // Idle pins sit at the released level, as through a pull resistor
    always_comb begin
        pins = {16{~level}};
        pins[idx] = held ? level : ~level;
    end
endmodule : bdr_switch_model

// ---- dv/test_button_debounce_autorepeat.sv ----
`timescale 1ns/1ps
module test_button_debounce_autorepeat;
    logic        mclk, rstn, invoke, press, lvl, tgt, done, branch_taken;
    logic [3:0]  sel;
    logic [7:0]  dly, rt, ws, ws_in, ws_out;
    logic [15:0] pins, pin_dir_in;
    int          mismatches = 0;
    int          num_checks = 0;

    bdr_switch_model sw (.held(press), .idx(sel), .level(lvl), .pins(pins));
    bdr_button #(.PINS(16)) uut (.mclk(mclk), .rstn(rstn), .pin_in(pins),
        .pin_dir_in(pin_dir_in), .invoke(invoke), .pin_sel(sel), .pressed_level(lvl),
        .delay(dly), .rate(rt), .branch_condition_level(tgt), .ws_in(ws_in),
        .done(done), .branch_taken(branch_taken), .ws_out(ws_out));

    initial mclk = 1'b0;
    always #10 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One invocation; pin settles past the synchroniser first
    task automatic step(input logic pr);
        logic       a;
        logic [8:0] n;
        int         i;
        press = pr;
        repeat (5) @(posedge mclk);
        #1 invoke = 1'b1;
        @(posedge mclk);
        #1 invoke = 1'b0;
        i = 0;
        do begin
            @(posedge mclk);
            #1;
            i++;
        end while (done !== 1'b1 && i < 8);
        a = 1'b0;
        n = {1'b0, ws};
        if (!pr) begin
            n = 9'h000;
        end else if (dly == 8'h00) begin
            a = 1'b1;
        end else if (ws == 8'h00) begin
            a = 1'b1;
            n = 9'h001;
        end else if (dly == 8'hff) begin
            n = 9'h001;
        end else if (ws < dly) begin
            n = ws + 9'h001;
            a = (n == {1'b0, dly});
        end else begin
            n = ws + 9'h001;
            // Top of the byte ends the period early instead of wrapping
            if (n >= {1'b0, dly} + {1'b0, rt} || ws == 8'hff) begin
                a = 1'b1;
                n = {1'b0, dly};
            end
        end
        chk(16'(i), 16'h0001);
        chk(16'(done), 16'h0001);
        chk(16'(branch_taken), 16'(a == tgt));
        chk(16'(ws_out), 16'(n[7:0]));
        chk(16'(pin_dir_in[sel]), 16'h0001);
        ws = n[7:0];
        ws_in = ws_out;
        @(posedge mclk);
        #1 chk(16'(done), 16'h0000);
    endtask : step

    task automatic run(input logic [3:0] s, input logic l, input logic [7:0] d,
                       input logic [7:0] r, input logic t, input int k);
        sel = s; lvl = l; dly = d; rt = r; tgt = t;
        ws = 8'h00;
        ws_in = 8'h00;
        repeat (k) step(1'b1);
        step(1'b0);
        // One-cycle contact glitch must not read as a press
        press = 1'b1;
        @(posedge mclk);
        #1 step(1'b0);
        step(1'b1);
    endtask : run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0; invoke = 1'b0; press = 1'b0; sel = 4'h0; lvl = 1'b0;
        dly = 8'h00; rt = 8'h00; tgt = 1'b1; ws_in = 8'h00; ws = 8'h00;
        repeat (20) @(posedge mclk);
        #1 rstn = 1'b1;
        @(posedge mclk);
        #1 chk(pin_dir_in, 16'h0000);
        run(4'h7, 1'b0, 8'h00, 8'h00, 1'b1, 3);
        run(4'h0, 1'b1, 8'h00, 8'h00, 1'b0, 2);
        run(4'hf, 1'b1, 8'h03, 8'h02, 1'b1, 10);
        run(4'h3, 1'b0, 8'h04, 8'h00, 1'b1, 7);
        run(4'h9, 1'b0, 8'hff, 8'h01, 1'b1, 5);
        run(4'h5, 1'b1, 8'h02, 8'h03, 1'b0, 9);
        final_report;
    end

    // Some fifty invocations of eight cycles each
    initial begin
        #200000;
        mismatches++;
        final_report;
    end
endmodule : test_button_debounce_autorepeat

// ---- rtl/bdr_button.sv ----
`timescale 1ns/1ps
module bdr_button #(
    parameter int PINS = bdr_pkg::PIN_CNT
) (
    // Clock and reset
    input  wire logic                            mclk,
    input  wire logic                            rstn,
    // Pins
    input  wire logic [PINS-1:0]                 pin_in,
    output logic      [PINS-1:0]                 pin_dir_in,
    // Invocation parameters
    input  wire logic                            invoke,
    input  wire logic [bdr_pkg::PIN_IDX_W-1:0]   pin_sel,
    input  wire logic                            pressed_level,
    input  wire logic [bdr_pkg::CNT_W-1:0]       delay,
    input  wire logic [bdr_pkg::CNT_W-1:0]       rate,
    input  wire logic                            branch_condition_level,
    input  wire logic [bdr_pkg::CNT_W-1:0]       ws_in,
    // Results
    output logic                                 done,
    output logic                                 branch_taken,
    output logic      [bdr_pkg::CNT_W-1:0]       ws_out
);

    ////////////////////////////////////////////////////////////////////////////
    logic [PINS-1:0] pin_s;

    bdr_pin_sync #(.W(PINS)) u_sync (
        .mclk     (mclk),
        .rstn     (rstn),
        .pin_raw  (pin_in),
        .pin_sync (pin_s)
    );

    typedef struct packed {
        bdr_pkg::bdr_state_e         state;
        logic [PINS-1:0]             dir_in;
        logic                        done;
        logic                        branch;
        logic [bdr_pkg::CNT_W-1:0]   ws;
    } bdr_st_s;

    bdr_st_s st_q;
    bdr_st_s st_d;

    localparam bdr_st_s ST_RST = '{
        state:  bdr_pkg::BDR_IDLE,
        dir_in: '0,
        done:   1'b0,
        branch: 1'b0,
        ws:     bdr_pkg::WS_CLEAR
    };

    ////////////////////////////////////////////////////////////////////////////
    // Workspace: 0 = released or delay zero; 1 with delay 255; else invocations held, up to 255 at most, then set back to delay when a repeat is due
    logic                       pressed;
    logic                       act;
    logic [bdr_pkg::CNT_W-1:0]  ws_nx;

    function automatic logic [bdr_pkg::CNT_W-1:0] cnt_inc(
        input logic [bdr_pkg::CNT_W-1:0] v
    );
        cnt_inc = v + bdr_pkg::CNT_ONE;
    endfunction : cnt_inc

    // Repeat period over; cut short at the top of the byte, since wrapping
    // to zero would read as a fresh press and act out of turn
    function automatic logic rep_due(
        input logic [bdr_pkg::CNT_W-1:0] ws,
        input logic [bdr_pkg::CNT_W-1:0] dly,
        input logic [bdr_pkg::CNT_W-1:0] rt
    );
        logic [bdr_pkg::CNT_W-1:0] pos;
        pos     = ws - dly;
        rep_due = (rt == bdr_pkg::WS_CLEAR) || (ws == bdr_pkg::WS_MAX)
                  || (pos >= rt - bdr_pkg::CNT_ONE);
    endfunction : rep_due

    always_comb begin
        pressed = (pin_s[pin_sel] == pressed_level);
        act     = 1'b0;
        ws_nx   = ws_in;
        if (!pressed) begin
            ws_nx = bdr_pkg::WS_CLEAR;
        end else if (delay == bdr_pkg::DELAY_NONE) begin
            act   = 1'b1;
            ws_nx = bdr_pkg::WS_CLEAR;
        end else if (ws_in == bdr_pkg::WS_CLEAR) begin
            act   = 1'b1;
            ws_nx = bdr_pkg::CNT_ONE;
        end else if (delay == bdr_pkg::DELAY_NO_REP) begin
            ws_nx = ws_in;
        end else if (ws_in < delay) begin
            ws_nx = cnt_inc(ws_in);
            if (ws_nx == delay) begin
                act = 1'b1;
            end
        end else begin
            // Past delay: ws counts delay..delay+rate-1, stopping short at 255, then wraps to delay
            if (rep_due(ws_in, delay, rate)) begin
                act   = 1'b1;
                ws_nx = delay;
            end else begin
                ws_nx = cnt_inc(ws_in);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d        = st_q;
        st_d.done   = 1'b0;
        st_d.branch = 1'b0;
        unique case (st_q.state)
            bdr_pkg::BDR_IDLE: begin
                if (invoke) begin
                    st_d.dir_in[pin_sel] = 1'b1;
                    st_d.state           = bdr_pkg::BDR_EVAL;
                end
            end
            bdr_pkg::BDR_EVAL: begin
                // Pin now an input; sample it once
                st_d.ws     = ws_nx;
                st_d.branch = (act == branch_condition_level);
                st_d.done   = 1'b1;
                st_d.state  = bdr_pkg::BDR_DONE;
            end
            bdr_pkg::BDR_DONE: begin
                st_d.state = bdr_pkg::BDR_IDLE;
            end
            default: begin
                st_d.state = bdr_pkg::BDR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_dir_in   = st_q.dir_in;
    assign done         = st_q.done;
    assign branch_taken = st_q.branch;
    assign ws_out       = st_q.ws;

    ////////////////////////////////////////////////////////////////////////////
    AST_DONE_TWO: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_IDLE && invoke) |-> ##2 done)
        else $error("done not two cycles after invoke");
    AST_DIR_IN: assert property (@(posedge mclk) disable iff (!rstn)
        done |-> pin_dir_in[$past(pin_sel)])
        else $error("pin not forced to input");
    AST_REL_CLR: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && !pressed) |=> ws_out == bdr_pkg::WS_CLEAR)
        else $error("workspace not cleared on release");
    AST_RAW: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && delay == bdr_pkg::DELAY_NONE && pressed
         && branch_condition_level) |=> branch_taken)
        else $error("zero delay did not act on press");
    AST_FIRST: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && pressed && ws_in == bdr_pkg::WS_CLEAR
         && delay != bdr_pkg::DELAY_NONE)
        |=> (ws_out != bdr_pkg::WS_CLEAR && branch_taken == $past(branch_condition_level)))
        else $error("first press not acted on");
    AST_NOREP: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && delay == bdr_pkg::DELAY_NO_REP && pressed
         && ws_in != bdr_pkg::WS_CLEAR && branch_condition_level) |=> !branch_taken)
        else $error("repeat with delay 255");
    AST_DELAY: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && pressed && delay != bdr_pkg::DELAY_NO_REP
         && ws_in != bdr_pkg::WS_CLEAR && cnt_inc(ws_in) == delay
         && branch_condition_level) |=> branch_taken)
        else $error("no action at delay");
    AST_COND: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && !pressed)
        |=> branch_taken == !$past(branch_condition_level))
        else $error("released branch mismatch");
    AST_DONE_PULSE: assert property (@(posedge mclk) disable iff (!rstn)
        done |=> !done)
        else $error("done longer than one cycle");
    AST_BRANCH_DONE: assert property (@(posedge mclk) disable iff (!rstn)
        branch_taken |-> done)
        else $error("branch outside completion");
    AST_WS_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        !done |-> $stable(ws_out))
        else $error("workspace moved between invocations");
    AST_ZERO_WS: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && delay == bdr_pkg::DELAY_NONE)
        |=> ws_out == bdr_pkg::WS_CLEAR)
        else $error("workspace used with zero delay");
    AST_RATE_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && pressed && delay != bdr_pkg::DELAY_NONE
         && delay != bdr_pkg::DELAY_NO_REP && ws_in >= delay && rate == bdr_pkg::WS_CLEAR
         && branch_condition_level) |=> branch_taken)
        else $error("no repeat every invocation with rate zero");
    AST_DIR_STICKY: assert property (@(posedge mclk) disable iff (!rstn)
        (pin_dir_in & $past(pin_dir_in)) == $past(pin_dir_in))
        else $error("forced input released");
    AST_CNT_STEP: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && pressed && delay != bdr_pkg::DELAY_NO_REP
         && ws_in != bdr_pkg::WS_CLEAR && ws_in < delay)
        |=> ws_out == cnt_inc($past(ws_in)))
        else $error("hold count did not advance");
    AST_NOREP_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
        (st_q.state == bdr_pkg::BDR_EVAL && pressed && delay == bdr_pkg::DELAY_NO_REP
         && ws_in != bdr_pkg::WS_CLEAR) |=> ws_out == $past(ws_in))
        else $error("workspace moved with delay 255");

endmodule : bdr_button

// ---- rtl/bdr_pin_sync.sv ----
`timescale 1ns/1ps
// Three-stage synchroniser for the pin bus; a change counts once stages 2 and 3 agree.
module bdr_pin_sync #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rstn,
    // Pins
    input  wire logic [W-1:0] pin_raw,
    output logic      [W-1:0] pin_sync
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } bdr_sync_s;

    bdr_sync_s st_q;
    bdr_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.stable[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pin_sync = st_q.stable;

endmodule : bdr_pin_sync

// ---- rtl/bdr_pkg.sv ----
package bdr_pkg;

    localparam int          PIN_CNT       = 16;
    localparam int          PIN_IDX_W     = 4;
    localparam int          CNT_W         = 8;
    localparam logic [7:0]  DELAY_NONE    = 8'h00;
    localparam logic [7:0]  DELAY_NO_REP  = 8'hff;
    localparam logic [7:0]  WS_CLEAR      = 8'h00;
    localparam logic [7:0]  CNT_ONE       = 8'h01;
    localparam logic [7:0]  WS_MAX        = 8'hff;
    localparam int          SYNC_STAGES   = 3;

    typedef enum logic [2:0] {
        BDR_IDLE = 3'b001,
        BDR_EVAL = 3'b010,
        BDR_DONE = 3'b100
    } bdr_state_e;

endpackage : bdr_pkg
